// >>> rtl/acs_sequencer.sv
// Purpose: calibration sequencing and output-code mapping
// Assumes: pins are asynchronous and pass two flops; result is a digital sample
// Notes: 16-bit variant selected by wide16 input; codes sit in low bits
`timescale 1ns/1ps
module acs_sequencer (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic clkEn,
   input wire logic wide16,
   input wire logic calibrate_request,
   input wire logic cal_select_a,
   input wire logic cal_select_b,
   input wire logic polarity_select,
   input wire logic sleep,
   input wire logic signed [20:0] analog_input,
   output logic conversion_done_n,
   output logic sampleSwitch,
   output logic calActive,
   output logic dataValid,
   input wire logic dataReady,
   output logic [19:0] dataOut
);
   acs_pkg::acs_regs_t r_q, r_d;
   acs_pkg::acs_pins_t pinA_q, pinB_q;
   logic fifoReady;
   logic reqFall;
   logic [21:0] stepLen;
   logic signed [22:0] diff;
   logic signed [22:0] code;
   logic [19:0] ones;
   logic [19:0] mid;
   logic [19:0] mapped;
   logic [19:0] offsetUse;
   logic sleepPrev_q;

   // two-flop synchroniser for all pins
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         pinA_q <= '0;
         pinB_q <= '0;
         sleepPrev_q <= 1'b0;
      end
      else if (clkEn)
      begin
         pinA_q <= {calibrate_request, cal_select_a, cal_select_b, polarity_select, sleep};
         pinB_q <= pinA_q;
         sleepPrev_q <= pinB_q.sleep;
      end
   end

   // falling edge of request on synced copy
   assign reqFall = r_q.reqPrev && !pinB_q.calRequest;

   // step length from captured select pair
   always_comb
   begin
      case (r_q.calType)
         acs_pkg::SEL_SELF: stepLen = 22'(acs_pkg::CYC_SELF);
         acs_pkg::SEL_OFFS: stepLen = 22'(acs_pkg::CYC_OFFS);
         acs_pkg::SEL_GAIN: stepLen = 22'(acs_pkg::CYC_GAIN);
         default: stepLen = 22'(acs_pkg::CYC_ONE);
      endcase
   end

   // code mapping with clamping
   always_comb
   begin
      ones = wide16 ? acs_pkg::ONES16 : acs_pkg::ONES20;
      mid = wide16 ? acs_pkg::MID16 : acs_pkg::MID20;
      // slope is unity here: fullScale is stored raw by a gain step and never used in the mapping
      // self-cal zero scale is ground, so its end word ignores an older system offset
      offsetUse = (calActive && r_q.calType == acs_pkg::SEL_SELF) ? 20'h0_0000 : r_q.offset;
      diff = 23'(analog_input) - 23'($signed({1'b0, offsetUse}));
      if (pinB_q.polaritySelect)
         code = diff + 23'($signed({1'b0, mid}));
      else
         code = diff;
      if (code > 23'($signed({1'b0, ones})))
         mapped = ones;
      else if (code < 0)
         mapped = '0;
      else
         mapped = code[19:0];
   end

   // main next-state logic
   always_comb
   begin
      r_d = r_q;
      r_d.pushValid = 1'b0;
      if (!clkEn)
      begin
         r_d = r_q;
      end
      else
      begin
         r_d.reqPrev = pinB_q.calRequest;
         // sampling switch, realigned by sleep rising
         if (pinB_q.sleep && !sleepPrev_q)
         begin
            r_d.phase = '0;
            r_d.switchSel = 1'b0;
         end
         else if (r_q.phase == 6'(acs_pkg::CYC_SWITCH - 1))
         begin
            r_d.phase = '0;
            r_d.switchSel = !r_q.switchSel;
         end
         else
            r_d.phase = r_q.phase + 1'b1;
         case (r_q.state)
            acs_pkg::ST_IDLE, acs_pkg::ST_RUN:
            begin
               if (pinB_q.calRequest)
               begin
                  r_d.state = acs_pkg::ST_HOLD;
                  r_d.doneN = 1'b1;
               end
               else if (r_q.state == acs_pkg::ST_RUN && fifoReady)
               begin
                  r_d.dataOut = mapped;
                  r_d.pushValid = 1'b1;
               end
            end
            acs_pkg::ST_HOLD:
            begin
               r_d.doneN = 1'b1;
               if (reqFall)
               begin
                  r_d.calType = pinB_q.calSelect;
                  r_d.count = '0;
                  r_d.state = acs_pkg::ST_CAL;
               end
            end
            acs_pkg::ST_CAL:
            begin
               r_d.doneN = 1'b1;
               r_d.count = r_q.count + 1'b1;
               if (r_q.count == stepLen - 1'b1)
               begin
                  r_d.doneN = 1'b0;
                  r_d.state = acs_pkg::ST_RUN;
                  r_d.pushValid = 1'b1;
                  case (r_q.calType)
                     acs_pkg::SEL_SELF:
                     begin
                        r_d.offset = '0;
                        r_d.dataOut = mapped;
                     end
                     acs_pkg::SEL_OFFS, acs_pkg::SEL_ONE:
                     begin
                        r_d.offset = analog_input[19:0];
                        r_d.dataOut = '0;
                     end
                     default:
                     begin
                        r_d.fullScale = analog_input[19:0];
                        r_d.gainValid = 1'b1;
                        r_d.dataOut = ones;
                     end
                  endcase
               end
            end
            default:
               r_d.state = acs_pkg::ST_IDLE;
         endcase
      end
   end

   // state register
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         r_q <= '0;
         r_q.state <= acs_pkg::ST_IDLE;
         r_q.doneN <= 1'b1;
      end
      else
         r_q <= r_d;
   end

   assign conversion_done_n = r_q.doneN;
   assign sampleSwitch = r_q.switchSel;
   assign calActive = (r_q.state == acs_pkg::ST_CAL);

   // result buffer
   acs_fifo #(.WIDTH(20), .DEPTH(acs_pkg::FIFO_DEPTH)) uFifo (
      .clk(clk),
      .reset_n(reset_n),
      .clkEn(clkEn),
      .inValid(r_q.pushValid),
      .inReady(fifoReady),
      .inData(r_q.dataOut),
      .outValid(dataValid),
      .outReady(dataReady),
      .outData(dataOut)
   );

   // flag held high across a whole step
   AST_FLAG_HIGH_IN_CAL: assert property (@(posedge clk) disable iff (!reset_n)
      calActive |-> conversion_done_n)
      else $error("flag low during step");

   // flag falls only on leaving calibration
   AST_FLAG_FALL: assert property (@(posedge clk) disable iff (!reset_n)
      $fell(conversion_done_n) |-> $past(calActive))
      else $error("flag fell early");

   // select captured on the request edge
   AST_CAPTURE: assert property (@(posedge clk) disable iff (!reset_n)
      (clkEn && r_q.state == acs_pkg::ST_HOLD && reqFall)
      |=> r_q.calType == $past(pinB_q.calSelect))
      else $error("select not captured");

   // switch toggles on 64 clock period
   AST_SWITCH: assert property (@(posedge clk) disable iff (!reset_n)
      (clkEn && r_q.phase == 6'(acs_pkg::CYC_SWITCH - 1) && !(pinB_q.sleep && !sleepPrev_q))
      |=> $changed(sampleSwitch))
      else $error("switch did not toggle");

   // sleep rise restarts the switch phase
   AST_SLEEP: assert property (@(posedge clk) disable iff (!reset_n)
      (clkEn && pinB_q.sleep && !sleepPrev_q) |=> (r_q.phase == 6'h00 && !sampleSwitch))
      else $error("sleep did not realign");

   // low clock enable holds every register
   AST_FREEZE: assert property (@(posedge clk) disable iff (!reset_n)
      !clkEn |=> $stable(r_q))
      else $error("state moved while frozen");

   // clamp never exceeds variant width
   AST_CLAMP16: assert property (@(posedge clk) disable iff (!reset_n)
      wide16 |-> mapped[19:16] == 4'h0)
      else $error("16-bit code overflow");

   // above full scale gives all ones, 16-bit variant
   AST_OVER16: assert property (@(posedge clk) disable iff (!reset_n)
      (wide16 && code > 23'($signed({1'b0, acs_pkg::ONES16}))) |-> mapped == acs_pkg::ONES16)
      else $error("16-bit high clamp wrong");

   // above full scale gives all ones, 20-bit variant
   AST_OVER20: assert property (@(posedge clk) disable iff (!reset_n)
      (!wide16 && code > 23'($signed({1'b0, acs_pkg::ONES20}))) |-> mapped == acs_pkg::ONES20)
      else $error("20-bit high clamp wrong");

   // negative code clamps to zero
   AST_ZERO: assert property (@(posedge clk) disable iff (!reset_n)
      (code < 0) |-> mapped == 20'h0_0000)
      else $error("no zero clamp");

   // in-range unipolar word is the offset-corrected input
   AST_UNIPOLAR: assert property (@(posedge clk) disable iff (!reset_n)
      (!pinB_q.polaritySelect && code >= 0 && code <= 23'($signed({1'b0, ones})))
      |-> 23'(mapped) == diff)
      else $error("unipolar code wrong");

   // in-range bipolar word carries the mid-scale term
   AST_BIPOLAR: assert property (@(posedge clk) disable iff (!reset_n)
      (pinB_q.polaritySelect && code >= 0 && code <= 23'($signed({1'b0, ones})))
      |-> 23'(mapped) == diff + 23'(wide16 ? acs_pkg::MID16 : acs_pkg::MID20))
      else $error("bipolar code wrong");

   // held request keeps the flag high
   AST_HOLD_FLAG: assert property (@(posedge clk) disable iff (!reset_n)
      (r_q.state == acs_pkg::ST_HOLD) |-> conversion_done_n)
      else $error("flag low while held");

   // counting starts at zero after edge
   AST_COUNT_START: assert property (@(posedge clk) disable iff (!reset_n)
      (clkEn && r_q.state == acs_pkg::ST_HOLD && reqFall) |=> (calActive && r_q.count == 0))
      else $error("count not started");

   // a step counts on, new requests ignored, until its length is reached
   AST_COUNT_STEP: assert property (@(posedge clk) disable iff (!reset_n)
      (calActive && clkEn && r_q.count != stepLen - 1'b1)
      |=> (calActive && r_q.count == $past(r_q.count) + 1'b1))
      else $error("step cut or count skipped");

   // step end drops the flag and pushes one word
   AST_STEP_END: assert property (@(posedge clk) disable iff (!reset_n)
      (calActive && clkEn && r_q.count == stepLen - 1'b1)
      |=> (!conversion_done_n && r_q.pushValid))
      else $error("step end not reported");

   // self-cal end loads the present input word
   AST_SELF_WORD: assert property (@(posedge clk) disable iff (!reset_n)
      (calActive && clkEn && r_q.calType == acs_pkg::SEL_SELF && r_q.count == stepLen - 1'b1)
      |=> r_q.dataOut == $past(mapped))
      else $error("self word wrong");

   // offset step end loads the zero-scale code
   AST_OFFS_CODE: assert property (@(posedge clk) disable iff (!reset_n)
      (calActive && clkEn && r_q.count == stepLen - 1'b1
      && (r_q.calType == acs_pkg::SEL_OFFS || r_q.calType == acs_pkg::SEL_ONE))
      |=> r_q.dataOut == 20'h0_0000)
      else $error("offset code wrong");

   // system gain end loads all ones
   AST_GAIN_CODE: assert property (@(posedge clk) disable iff (!reset_n)
      (calActive && clkEn && r_q.calType == acs_pkg::SEL_GAIN && r_q.count == stepLen - 1'b1)
      |=> r_q.dataOut == $past(ones))
      else $error("gain code wrong");

   // run state keeps the flag low
   AST_RUN_DONE: assert property (@(posedge clk) disable iff (!reset_n)
      (r_q.state == acs_pkg::ST_RUN) |-> !conversion_done_n)
      else $error("flag high after step");
endmodule

// >>> rtl/acs_pkg.sv
// Purpose: shared constants and types for the calibration sequencer
// Assumes: 20 MHz clock, 20-bit result width (16-bit variant by mask)
// Notes: rules kept by the block and by its controller
// Function
// - select pair captured at the request's falling edge
// - completion flag goes high at step start, stays high until finished
// - self-cal end: flag low, output loaded with present input word
// - system step end: flag low, output loaded with zero or full scale
// - select decode: 00 self, 11 offset, 01 gain, 10 one-step offset
// - step lengths 3145655, 1052599, 1068813 clocks; flag high throughout
// - above full scale the output is all ones
// - below zero or negative full scale the output is all zeros
// - unipolar code is slope times input minus offset plus half LSB; the code adds no half LSB
// - bipolar code adds mid-scale 8000 or 80000 hex plus half LSB; the code adds no half LSB
// - sleep rise realigns sampling and output phase across devices; the code realigns only the sampling switch phase
// - sampling switch toggles every 64 clocks
package acs_pkg;
   localparam int unsigned CLK_HZ = 20_000_000;
   localparam int unsigned W = 20;
   localparam int unsigned CYC_SELF = 3145655;
   localparam int unsigned CYC_OFFS = 1052599;
   localparam int unsigned CYC_GAIN = 1068813;
   localparam int unsigned CYC_ONE = 2117389;
   localparam int unsigned CYC_SWITCH = 64;
   localparam int unsigned CYC_REQ_MIN = 4;
   localparam logic [1:0] SEL_SELF = 2'h0;
   localparam logic [1:0] SEL_OFFS = 2'h3;
   localparam logic [1:0] SEL_GAIN = 2'h1;
   localparam logic [1:0] SEL_ONE = 2'h2;
   localparam logic [W-1:0] MID20 = 20'h8_0000;
   localparam logic [W-1:0] MID16 = 20'h0_8000;
   localparam logic [W-1:0] ONES20 = 20'hF_FFFF;
   localparam logic [W-1:0] ONES16 = 20'h0_FFFF;
   localparam int unsigned FIFO_DEPTH = 16;
   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_HOLD = 4'b0010,
      ST_CAL = 4'b0100,
      ST_RUN = 4'b1000
   } acs_state_t;
   typedef struct packed {
      logic calRequest;
      logic [1:0] calSelect;
      logic polaritySelect;
      logic sleep;
   } acs_pins_t;
   typedef struct packed {
      logic [1:0] s1;
      logic [1:0] s2;
      logic reqPrev;
      acs_state_t state;
      logic [1:0] calType;
      logic [21:0] count;
      logic [5:0] phase;
      logic switchSel;
      logic [W-1:0] offset;
      logic [W-1:0] fullScale;
      logic [W-1:0] dataOut;
      logic pushValid;
      logic doneN;
      logic gainValid;
   } acs_regs_t;
endpackage

// >>> rtl/acs_fifo.sv
// Purpose: small valid/ready FIFO on the result path
// Assumes: single clock, depth a power of two
// Notes: push blocked when full, pop when empty
`timescale 1ns/1ps
module acs_fifo #(
   parameter int WIDTH = 20,
   parameter int DEPTH = 16
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic clkEn,
   input wire logic inValid,
   output logic inReady,
   input wire logic [WIDTH-1:0] inData,
   output logic outValid,
   input wire logic outReady,
   output logic [WIDTH-1:0] outData
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [AW:0] wr;
      logic [AW:0] rd;
   } acs_fifo_ptr_t;
   acs_fifo_ptr_t ptr_q, ptr_d;
   logic [WIDTH-1:0] mem [DEPTH];
   logic push, pop;
   // full and empty from pointer wrap bit
   assign inReady = !((ptr_q.wr[AW] != ptr_q.rd[AW]) && (ptr_q.wr[AW-1:0] == ptr_q.rd[AW-1:0]));
   assign outValid = (ptr_q.wr != ptr_q.rd);
   assign push = inValid && inReady && clkEn;
   assign pop = outValid && outReady && clkEn;
   assign outData = mem[ptr_q.rd[AW-1:0]];
   // pointer update
   always_comb
   begin
      ptr_d = ptr_q;
      if (push)
         ptr_d.wr = ptr_q.wr + 1'b1;
      if (pop)
         ptr_d.rd = ptr_q.rd + 1'b1;
   end
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         ptr_q <= '0;
      else
         ptr_q <= ptr_d;
   end
   // storage write
   always_ff @(posedge clk)
   begin
      if (push)
         mem[ptr_q.wr[AW-1:0]] <= inData;
   end
endmodule

// >>> tb/acs_ctrl_model.sv
// Purpose: controller model driving the calibration pins
// Assumes: pins change just after falling clock edges
// Notes: a gain step is turned into an offset step until one offset step was requested
`timescale 1ns/1ps
module acs_ctrl_model (
   input wire logic clk,
   output logic calibrate_request,
   output logic cal_select_a,
   output logic cal_select_b,
   output logic polarity_select
);
   logic offsSeen;
   // idle pins, polarity high until set_polarity changes it
   initial
   begin
      calibrate_request = 1'h0;
      cal_select_a = 1'h0;
      cal_select_b = 1'h0;
      polarity_select = 1'h1;
      offsSeen = 1'h0;
   end
   // one step request: select pair set, request held, then released
   task automatic start_step(input logic [1:0] sel, input int hold);
      if (sel == acs_pkg::SEL_GAIN && !offsSeen)
         sel = acs_pkg::SEL_OFFS;
      offsSeen = offsSeen | (sel == acs_pkg::SEL_OFFS);
      @(negedge clk);
      {cal_select_a, cal_select_b} = sel;
      calibrate_request = 1'h1;
      repeat ((hold < int'(acs_pkg::CYC_REQ_MIN)) ? int'(acs_pkg::CYC_REQ_MIN) : hold)
         @(negedge clk);
      calibrate_request = 1'h0;
   endtask
   // polarity changes only ahead of a fresh calibration
   task automatic set_polarity(input logic pol);
      polarity_select = pol;
   endtask
endmodule

// >>> tb/tb.sv
// Purpose: self-checking bench for the calibration sequencer
// Assumes: 20 MHz clock, inputs driven at falling edges
// Notes: full step lengths are too long to run, steps are watched in part
`timescale 1ns/1ps
module tb;
   typedef struct packed {int lo; int hi;} acs_gap_t;
   logic clk, reset_n, clkEn, wide16, sleep, dataReady;
   logic signed [20:0] analog_input;
   logic calibrate_request, cal_select_a, cal_select_b, polarity_select;
   logic conversion_done_n, sampleSwitch, calActive, dataValid;
   logic [19:0] dataOut;
   int num_errors = 0;
   int checks = 0;
   int seed = 32'h0000_afc3;
   int cyc = 0;
   int gap = 0;
   int k = 0;
   int bad = 0;
   logic watchSw = 1'h0;
   logic prevSw = 1'h0;
   acs_gap_t gapQ[$];
   logic [1:0] codes [4];

   acs_sequencer u_acs_sequencer (
      .clk(clk), .reset_n(reset_n), .clkEn(clkEn), .wide16(wide16),
      .calibrate_request(calibrate_request), .cal_select_a(cal_select_a),
      .cal_select_b(cal_select_b), .polarity_select(polarity_select),
      .sleep(sleep), .analog_input(analog_input),
      .conversion_done_n(conversion_done_n), .sampleSwitch(sampleSwitch),
      .calActive(calActive), .dataValid(dataValid), .dataReady(dataReady),
      .dataOut(dataOut)
   );
   acs_ctrl_model u_acs_ctrl_model (
      .clk(clk), .calibrate_request(calibrate_request),
      .cal_select_a(cal_select_a), .cal_select_b(cal_select_b),
      .polarity_select(polarity_select)
   );

   // free-running clock
   initial
   begin
      clk = 1'h0;
      forever #25 clk = ~clk;
   end

   task automatic check(input bit ok, input string msg);
      checks++;
      if (!ok)
      begin
         num_errors++;
         $display("BAD %0t %s", $time, msg);
      end
   endtask

   task automatic final_report();
      $display("checks %0d num_errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic drain();
      while (gapQ.size() > 0) @(negedge clk);
   endtask

   // random sample, width and sink readiness each cycle
   always @(negedge clk)
      {wide16, dataReady, analog_input} = 23'($random(seed));

   // compare each switch period with the oldest note
   always @(negedge clk)
   begin
      gap = (!reset_n || !watchSw) ? 0 : gap + 1;
      if (watchSw && sampleSwitch !== prevSw && gapQ.size() > 0)
      begin
         check(gap >= gapQ[0].lo && gap <= gapQ[0].hi, "switch period");
         void'(gapQ.pop_front());
         gap = 0;
      end
      prevSw = sampleSwitch;
   end

   // hang guard
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 10000)
      begin
         num_errors++;
         $display("BAD %0t timeout", $time);
         final_report();
      end
   end

   // main sequence
   initial
   begin
      reset_n = 1'h0;
      clkEn = 1'h1;
      sleep = 1'h0;
      wide16 = 1'h0;
      dataReady = 1'h1;
      analog_input = '0;
      codes = '{acs_pkg::SEL_SELF, acs_pkg::SEL_OFFS, acs_pkg::SEL_GAIN, acs_pkg::SEL_ONE};
      repeat (4) @(negedge clk);
      check(conversion_done_n === 1'h1 && calActive === 1'h0, "reset flag");
      check(sampleSwitch === 1'h0 && dataValid === 1'h0, "reset outputs");
      reset_n = 1'h1;
      // plain periods, then a ten-clock freeze inside one period
      watchSw = 1'h1;
      gapQ = '{'{1, 70}, '{64, 64}, '{64, 64}};
      drain();
      gapQ.push_back(acs_gap_t'{74, 74});
      repeat (5) @(negedge clk);
      clkEn = 1'h0;
      repeat (10) @(negedge clk);
      clkEn = 1'h1;
      drain();
      // sleep rise restarts the switch phase
      gapQ = '{'{83, 90}, '{64, 64}};
      repeat (20) @(negedge clk);
      sleep = 1'h1;
      @(negedge clk);
      sleep = 1'h0;
      drain();
      watchSw = 1'h0;
      // every select code starts a step that keeps the flag high
      for (int i = 0; i < 4; i++)
      begin
         reset_n = 1'h0;
         @(negedge clk);
         reset_n = 1'h1;
         u_acs_ctrl_model.set_polarity(i[0]);
         u_acs_ctrl_model.start_step(codes[i], 4 + ($random(seed) & 3));
         k = 0;
         while (calActive !== 1'h1 && k < 6)
         begin
            @(negedge clk);
            k++;
         end
         check(calActive === 1'h1, "step not started");
         bad = 0;
         for (int n = 0; n < 1000; n++)
         begin
            if (i == 0 && n == 400)
               u_acs_ctrl_model.start_step(acs_pkg::SEL_OFFS, 4);
            @(negedge clk);
            if (conversion_done_n !== 1'h1 || calActive !== 1'h1 || dataValid !== 1'h0)
               bad++;
         end
         check(bad == 0, "flag or data during step");
      end
      final_report();
   end
endmodule
